// *** include/sfa_cfg.svh ***
// Offsets, field positions, reset values and timing of the fault/ack block
`ifndef SFA_CFG_SVH
`define SFA_CFG_SVH
// Register byte offsets
`define SFA_CTRL_OFF 8'h00
`define SFA_CW0_OFF 8'h04
`define SFA_CW1_OFF 8'h08
`define SFA_STAT_OFF 8'h0C
`define SFA_TOL_OFF 8'h10
`define SFA_TELEG_OFF 8'h14
`define SFA_SACK_OFF 8'h18
// Control register fields
`define SFA_CTRL_RAMP 0
`define SFA_CTRL_LOCK 1
`define SFA_CTRL_EXTFB 2
`define SFA_CTRL_BASIC 3
`define SFA_CTRL_FSIN 4
// Safety control word fields
`define SFA_CW_STO 0
`define SFA_CW_SS1 1
`define SFA_CW_ACK 7
`define SFA_CW_POSDES 12
`define SFA_CW_NEGDES 13
// Status register fields
`define SFA_ST_TOFF 0
`define SFA_ST_RAMP 1
`define SFA_ST_EVENT 7
`define SFA_ST_DISC 8
`define SFA_ST_EVAL 9
`define SFA_ST_INH 10
`define SFA_ST_POS 12
`define SFA_ST_NEG 13
// Reset values
`define SFA_CTRL_RST 5'h00
`define SFA_CW_RST 16'hFFFF
`define SFA_TOL_RST 16'h0064
// Timing: tolerance counted in 1 ms ticks of a 40 ns clock
`define SFA_CLK_PERIOD_NS 40
`define SFA_TICK_US 1000
`endif

// *** include/sfa_pkg.sv ***
// Types shared by the fault/ack block
`default_nettype none
package sfa_pkg;
  typedef enum logic [1:0] {SFA_SQ_WAIT, SFA_SQ_ARM, SFA_SQ_MID} sfa_seq_t;
  typedef struct packed {
    sfa_seq_t st;
    logic hit;
  } sfa_det_st_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [4:0] ctrl;
    logic [15:0] cw0;
    logic [15:0] cw1;
    logic [15:0] tol;
    logic [1:0] teleg;
    logic sack;
    logic event_f;
    logic toff;
    logic ramp;
    logic inh;
    logic disc;
    logic eval;
    logic [15:0] tolcnt;
    logic [15:0] tickcnt;
    logic tick;
  } sfa_main_st_t;
endpackage
`default_nettype wire

// *** hw/sfa_sync3.sv ***
// Three-stage synchroniser with agreement filter for pin inputs
`default_nettype none
module sfa_sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  // A zero-wide synchroniser has nothing to carry
  if (W < 1) begin : g_chk
    $error("W must be at least 1");
  end

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // Only stage two reads stage one; a change counts once 2 and 3 agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      dout <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          dout[i] <= s3_r[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** hw/sfa_seq_det.sv ***
// Three-level sequence detector (idle, opposite, idle) on one bit
`default_nettype none
module sfa_seq_det #(
  parameter logic IDLE_LVL = 1'b0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Sampled bit and detection pulse
  input wire logic smp,
  output logic hit
);
  sfa_pkg::sfa_det_st_t st_r;
  sfa_pkg::sfa_det_st_t st_nxt;

  // Each level must be seen in order; a lone level never fires
  always_comb begin
    st_nxt = st_r;
    st_nxt.hit = 1'b0;
    unique case (st_r.st)
      sfa_pkg::SFA_SQ_WAIT: begin
        if (smp == IDLE_LVL) st_nxt.st = sfa_pkg::SFA_SQ_ARM;
      end
      sfa_pkg::SFA_SQ_ARM: begin
        if (smp != IDLE_LVL) st_nxt.st = sfa_pkg::SFA_SQ_MID;
      end
      sfa_pkg::SFA_SQ_MID: begin
        if (smp == IDLE_LVL) begin
          st_nxt.st = sfa_pkg::SFA_SQ_ARM;
          st_nxt.hit = 1'b1;
        end
      end
      default: st_nxt.st = sfa_pkg::SFA_SQ_WAIT;
    endcase
  end

  // Start waiting so a level held over reset is not a half sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{st: sfa_pkg::SFA_SQ_WAIT, hit: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hit = st_r.hit;
endmodule
`default_nettype wire

// *** hw/sfa_ack_logic.sv ***
// Safety fault response and acknowledgment logic with APB registers
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`include "sfa_cfg.svh"
`default_nettype none
module sfa_ack_logic #(
  parameter int TICK_CYCLES = `SFA_TICK_US * 1000 / `SFA_CLK_PERIOD_NS
) (
  // Clock and power-up reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Motion monitor and drive state
  input wire logic limit_fault,
  input wire logic standstill,
  input wire logic run_command,
  // Fail-safe input pins
  input wire logic failsafe_input_ack,
  input wire logic failsafe_input_sto,
  input wire logic failsafe_input_ss1,
  // Stop paths and flags
  output logic torque_off_active_flag,
  output logic ramp_stop_active,
  output logic internal_event_flag,
  output logic discrepancy_fault,
  output logic evaluated_input,
  output logic restart_inhibit
);
  localparam int TOL_W = 16;
  // Detector idle levels: 0 for low-high-low, 1 for high-low-high
  localparam logic [8:0] DET_IDLE = 9'h0FC;

  if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_chk
    $error("TICK_CYCLES out of range");
  end

  sfa_pkg::sfa_main_st_t s_r;
  sfa_pkg::sfa_main_st_t s_nxt;
  logic [2:0] fs_sync;
  logic [8:0] det_src;
  logic [8:0] det_hit;
  logic pos_active;
  logic neg_active;
  logic sdm_active;
  logic fault_now;
  logic ev_ack;
  logic disc_ack;
  logic disagree;
  logic acc;
  logic setup;

  // Fail-safe pins come from outside the clock domain
  sfa_sync3 #(.W(3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({failsafe_input_ss1, failsafe_input_sto, failsafe_input_ack}),
    .dout(fs_sync)
  );

  // Ack sources, one detector each
  assign det_src = {s_r.cw1[`SFA_CW_ACK], s_r.cw1[`SFA_CW_SS1],
                    s_r.cw1[`SFA_CW_STO], fs_sync[2], fs_sync[1],
                    s_r.cw0[`SFA_CW_SS1], s_r.cw0[`SFA_CW_STO],
                    fs_sync[0], s_r.cw0[`SFA_CW_ACK]};

  for (genvar i = 0; i < 9; i++) begin : g_det
    sfa_seq_det #(.IDLE_LVL(DET_IDLE[i])) u_det (
      .pclk(pclk),
      .presetn(presetn),
      .smp(det_src[i]),
      .hit(det_hit[i])
    );
  end

  // Direction monitor selected while its deselect bit is low
  assign pos_active = ~s_r.cw0[`SFA_CW_POSDES];
  assign neg_active = ~s_r.cw0[`SFA_CW_NEGDES];
  assign sdm_active = pos_active | neg_active;
  assign fault_now = limit_fault & sdm_active;

  // Event acks: word 0 and fail-safe inputs
  assign ev_ack = det_hit[0]
      | (s_r.ctrl[`SFA_CTRL_FSIN] & det_hit[1])
      | det_hit[2] | det_hit[4]
      | det_hit[3] | det_hit[5];

  // Discrepancy acks depend on where the extended functions live
  assign disc_ack = s_r.ctrl[`SFA_CTRL_EXTFB]
      ? (|det_hit[8:6]
         | (s_r.ctrl[`SFA_CTRL_BASIC] & det_hit[4]))
      : ev_ack;

  assign disagree = s_r.teleg[0] ^ s_r.teleg[1];
  assign setup = psel & ~penable;
  assign acc = psel & penable & s_r.pready;

  // Next state of registers, stop paths and discrepancy tracking
  always_comb begin
    s_nxt = s_r;
    s_nxt.sack = 1'b0;
    s_nxt.tick = 1'b0;

    // Millisecond enable from the clock divider
    if (s_r.tickcnt == 16'(TICK_CYCLES - 1)) begin
      s_nxt.tickcnt = 16'h0000;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.tickcnt = s_r.tickcnt + 16'h0001;
    end

    // APB: decode in setup, answer in the first access cycle
    if (setup) begin
      s_nxt.pready = 1'b1;
      s_nxt.pslverr = 1'b0;
      s_nxt.prdata = 32'h0000_0000;
      unique case (paddr)
        `SFA_CTRL_OFF: s_nxt.prdata = {27'h0, s_r.ctrl};
        `SFA_CW0_OFF: s_nxt.prdata = {16'h0, s_r.cw0};
        `SFA_CW1_OFF: s_nxt.prdata = {16'h0, s_r.cw1};
        `SFA_STAT_OFF: begin
          s_nxt.prdata[`SFA_ST_TOFF] = s_r.toff;
          s_nxt.prdata[`SFA_ST_RAMP] = s_r.ramp;
          s_nxt.prdata[`SFA_ST_EVENT] = s_r.event_f;
          s_nxt.prdata[`SFA_ST_DISC] = s_r.disc;
          s_nxt.prdata[`SFA_ST_EVAL] = s_r.eval;
          s_nxt.prdata[`SFA_ST_INH] = s_r.inh;
          s_nxt.prdata[`SFA_ST_POS] = pos_active;
          s_nxt.prdata[`SFA_ST_NEG] = neg_active;
        end
        `SFA_TOL_OFF: s_nxt.prdata = {16'h0, s_r.tol};
        `SFA_TELEG_OFF: s_nxt.prdata = {30'h0, s_r.teleg};
        `SFA_SACK_OFF: s_nxt.prdata = 32'h0000_0000;
        default: s_nxt.pslverr = 1'b1;
      endcase
    end else if (acc) begin
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;
      if (pwrite && !s_r.pslverr) begin
        unique case (paddr)
          `SFA_CTRL_OFF: begin
            // Stop kind and modes freeze once locked
            if (!s_r.ctrl[`SFA_CTRL_LOCK]) begin
              s_nxt.ctrl = pwdata[4:0];
            end
          end
          `SFA_CW0_OFF: s_nxt.cw0 = pwdata[15:0];
          `SFA_CW1_OFF: s_nxt.cw1 = pwdata[15:0];
          `SFA_TOL_OFF: s_nxt.tol = pwdata[15:0];
          `SFA_TELEG_OFF: s_nxt.teleg = pwdata[1:0];
          `SFA_SACK_OFF: s_nxt.sack = pwdata[0];
          default: s_nxt.sack = 1'b0;
        endcase
      end
    end

    // Restart inhibit: cleared by standard ack with event gone, run low
    if (s_r.sack && !s_r.event_f && !run_command) begin
      s_nxt.inh = 1'b0;
    end

    // Internal event: a fail-safe ack clears, a new fault wins
    if (ev_ack) begin
      s_nxt.event_f = 1'b0;
      s_nxt.ramp = 1'b0;
    end
    if (fault_now) begin
      s_nxt.event_f = 1'b1;
      s_nxt.inh = 1'b1;
      if (!s_r.event_f) begin
        if (s_r.ctrl[`SFA_CTRL_RAMP]) begin
          s_nxt.ramp = ~s_r.toff;
        end else begin
          s_nxt.toff = 1'b1;
        end
      end
    end

    // Ramp stop ends in torque-off at standstill
    if (s_r.ramp && standstill && !ev_ack) begin
      s_nxt.ramp = 1'b0;
      s_nxt.toff = 1'b1;
    end

    // Torque released only after the event and inhibit are gone
    if (!s_nxt.event_f && !s_nxt.inh) begin
      s_nxt.toff = 1'b0;
    end

    // Discrepancy: count ticks of disagreement, never an event
    // The divider runs free, so the first tick may come after one cycle;
    // waiting for one tick past the setting guarantees the full tolerance
    if (!disagree) begin
      s_nxt.tolcnt = 16'h0000;
      if (disc_ack) begin
        s_nxt.disc = 1'b0;
      end
    end else if (s_r.tick && !s_r.disc) begin
      s_nxt.tolcnt = s_r.tolcnt + 16'h0001;
      if (s_r.tolcnt + 16'h0001 > s_r.tol) begin
        s_nxt.disc = 1'b1;
      end
    end

    // Evaluated input held at zero while the discrepancy stands
    if (s_nxt.disc) begin
      s_nxt.eval = 1'b0;
    end else if (!disagree) begin
      s_nxt.eval = s_r.teleg[0];
    end
  end

  // Power-up clears every flag, the event included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.ctrl <= `SFA_CTRL_RST;
      s_r.cw0 <= `SFA_CW_RST;
      s_r.cw1 <= `SFA_CW_RST;
      s_r.tol <= `SFA_TOL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state flops
  assign pready = s_r.pready;
  assign prdata = s_r.prdata;
  assign pslverr = s_r.pslverr;
  assign torque_off_active_flag = s_r.toff;
  assign ramp_stop_active = s_r.ramp;
  assign internal_event_flag = s_r.event_f;
  assign discrepancy_fault = s_r.disc;
  assign evaluated_input = s_r.eval;
  assign restart_inhibit = s_r.inh;

  // Checks on the stop, ack and discrepancy paths
  property p_event_set;
    @(posedge pclk) disable iff (!presetn)
    fault_now |=> s_r.event_f;
  endproperty
  a_event_set: assert property (p_event_set)
    else $error("fault did not raise the internal event");

  property p_toff_now;
    @(posedge pclk) disable iff (!presetn)
    fault_now && !s_r.event_f && !s_r.ctrl[`SFA_CTRL_RAMP]
      |=> s_r.toff && !s_r.ramp;
  endproperty
  a_toff_now: assert property (p_toff_now)
    else $error("torque-off stop not immediate");

  property p_ramp_end;
    @(posedge pclk) disable iff (!presetn)
    s_r.ramp && standstill && !ev_ack |=> s_r.toff && !s_r.ramp;
  endproperty
  a_ramp_end: assert property (p_ramp_end)
    else $error("ramp stop did not end in torque-off");

  property p_mode_lock;
    @(posedge pclk) disable iff (!presetn)
    s_r.ctrl[`SFA_CTRL_LOCK] |=> $stable(s_r.ctrl);
  endproperty
  a_mode_lock: assert property (p_mode_lock)
    else $error("stop setting changed after lock");

  property p_event_hold;
    @(posedge pclk) disable iff (!presetn)
    s_r.event_f && !ev_ack |=> s_r.event_f;
  endproperty
  a_event_hold: assert property (p_event_hold)
    else $error("event cleared without fail-safe ack");

  property p_fs_clear;
    @(posedge pclk) disable iff (!presetn)
    s_r.event_f && ev_ack && !fault_now |=> !s_r.event_f;
  endproperty
  a_fs_clear: assert property (p_fs_clear)
    else $error("fail-safe ack did not clear event");

  property p_disc_no_event;
    @(posedge pclk) disable iff (!presetn)
    !s_r.event_f && !fault_now |=> !s_r.event_f;
  endproperty
  a_disc_no_event: assert property (p_disc_no_event)
    else $error("event set without a limit fault");

  property p_disc_wait;
    @(posedge pclk) disable iff (!presetn)
    $rose(s_r.disc) |-> $past(s_r.tick) && $past(disagree);
  endproperty
  a_disc_wait: assert property (p_disc_wait)
    else $error("discrepancy reported off a tick");

  property p_eval_zero;
    @(posedge pclk) disable iff (!presetn)
    s_r.disc |-> !s_r.eval;
  endproperty
  a_eval_zero: assert property (p_eval_zero)
    else $error("evaluated input not forced to zero");

  property p_apb_answer;
    @(posedge pclk) disable iff (!presetn)
    setup |=> s_r.pready ##1 !s_r.pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("APB answer not in first access cycle");

  c_fault_ramp: cover property (@(posedge pclk) disable iff (!presetn)
    s_r.ramp ##1 s_r.toff);
  c_event_ack: cover property (@(posedge pclk) disable iff (!presetn)
    s_r.event_f ##1 !s_r.event_f);
  c_disc_set: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(s_r.disc));
endmodule
`default_nettype wire

// *** dv/sfa_fs_ctrl_model.sv ***
// Behavioural fail-safe controller driving the pins and the run command
`default_nettype none
module sfa_fs_ctrl_model #(
  parameter int HOLD = 6
) (
  // Clock
  input wire logic pclk,
  // Fail-safe pins and run command
  output logic failsafe_input_ack,
  output logic failsafe_input_sto,
  output logic failsafe_input_ss1,
  output logic run_command
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle levels: ack low, selects high (deselected), motor on
  initial begin
    failsafe_input_ack = 1'b0;
    failsafe_input_sto = 1'b1;
    failsafe_input_ss1 = 1'b1;
    run_command = 1'b1;
  end

  // Opposite level, then idle; held long enough for the pin filter
  task automatic pulse(input int which);
    for (int s = 0; s < 2; s++) begin
      @(posedge pclk);
      case (which)
        0: failsafe_input_ack <= ~failsafe_input_ack;
        1: failsafe_input_sto <= ~failsafe_input_sto;
        default: failsafe_input_ss1 <= ~failsafe_input_ss1;
      endcase
      repeat (HOLD) @(posedge pclk);
    end
  endtask

  // Run command low before acks, high only after the standard ack
  task automatic set_run(input logic v);
    @(posedge pclk);
    run_command <= v;
  endtask
endmodule
`default_nettype wire

// *** dv/tb_sfa_ack_logic.sv ***
// Self-checking bench for the fault and acknowledgment block
`include "sfa_cfg.svh"
`default_nettype none
module tb_sfa_ack_logic;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic limit_fault, standstill, run_command;
  logic fs_ack, fs_sto, fs_ss1;
  logic toff, ramp, evt, disc, eval, inh;
  logic [15:0] base;
  logic [31:0] cs [5];
  int ks [5];
  int fail_count, cmp_count;

  sfa_ack_logic #(.TICK_CYCLES(TICK)) sfa_ack_logic_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .limit_fault(limit_fault),
    .standstill(standstill), .run_command(run_command),
    .failsafe_input_ack(fs_ack), .failsafe_input_sto(fs_sto),
    .failsafe_input_ss1(fs_ss1), .torque_off_active_flag(toff),
    .ramp_stop_active(ramp), .internal_event_flag(evt),
    .discrepancy_fault(disc), .evaluated_input(eval),
    .restart_inhibit(inh)
  );

  sfa_fs_ctrl_model sfa_fs_ctrl_model_inst (
    .pclk(pclk), .failsafe_input_ack(fs_ack),
    .failsafe_input_sto(fs_sto), .failsafe_input_ss1(fs_ss1),
    .run_command(run_command)
  );

  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic report_and_stop();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      chk_bit(pready, 1'b1);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_word(rd, exp);
  endtask

  // Limit fault with direction monitoring on, then deselect it again
  task automatic fault();
    apb(1'b1, `SFA_CW0_OFF, {16'h0, base & 16'hEFFF});
    @(posedge pclk);
    limit_fault <= 1'b1;
    @(posedge pclk);
    limit_fault <= 1'b0;
    cyc(2);
    chk_bit(evt, 1'b1);
    apb(1'b1, `SFA_CW0_OFF, {16'h0, base});
  endtask

  // k: 0-2 word 0 bits 7/0/1, 3-5 pins, 6-8 word 1 bits 7/0/1
  task automatic ack(input int k);
    logic [15:0] m;
    logic [7:0] a;
    m = (k % 3 == 0) ? 16'h0080 : (k % 3 == 1) ? 16'h0001 : 16'h0002;
    a = (k < 3) ? `SFA_CW0_OFF : `SFA_CW1_OFF;
    if (k >= 3 && k < 6) begin
      sfa_fs_ctrl_model_inst.pulse(k - 3);
      cyc(5);
    end else begin
      apb(1'b1, a, {16'h0, base ^ m});
      cyc(3);
      chk_bit(evt | disc, 1'b1);
      apb(1'b1, a, {16'h0, base});
      cyc(3);
    end
  endtask

  // Hang guard
  initial begin
    #2000000;
    fail_count++;
    report_and_stop();
  end

  initial begin
    {presetn, psel, penable, pwrite, limit_fault, standstill} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    fail_count = 0;
    cmp_count = 0;
    base = 16'hFF7F;
    cs = '{32'h0, 32'h4, 32'h4, 32'h4, 32'hC};
    ks = '{0, 6, 7, 8, 4};
    cyc(5);
    presetn <= 1'b1;
    rdchk(`SFA_CTRL_OFF, 32'h0);
    rdchk(`SFA_CW0_OFF, 32'hFFFF);
    rdchk(`SFA_TOL_OFF, 32'h64);
    rdchk(`SFA_STAT_OFF, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk_bit(err, 1'b1);
    // Fault ignored while direction monitoring is off
    @(posedge pclk);
    limit_fault <= 1'b1;
    @(posedge pclk);
    limit_fault <= 1'b0;
    cyc(2);
    chk_bit(evt, 1'b0);
    // Event raised and cleared by every fail-safe ack source
    apb(1'b1, `SFA_CTRL_OFF, 32'h10);
    for (int k = 0; k < 6; k++) begin
      fault();
      chk_bit(toff, 1'b1);
      apb(1'b1, `SFA_SACK_OFF, 32'h1);
      cyc(2);
      chk_bit(evt, 1'b1);
      sfa_fs_ctrl_model_inst.set_run(1'b0);
      ack(k);
      chk_bit(evt, 1'b0);
      apb(1'b1, `SFA_SACK_OFF, 32'h1);
      cyc(2);
      chk_bit(inh, 1'b0);
      chk_bit(toff, 1'b0);
      sfa_fs_ctrl_model_inst.set_run(1'b1);
    end
    // Telegram discrepancy: late report, forced zero, ack per mode
    apb(1'b1, `SFA_TOL_OFF, 32'h3);
    apb(1'b1, `SFA_CW1_OFF, {16'h0, base});
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, `SFA_CTRL_OFF, cs[i]);
      apb(1'b1, `SFA_TELEG_OFF, 32'h3);
      cyc(2);
      chk_bit(eval, 1'b1);
      apb(1'b1, `SFA_TELEG_OFF, 32'h1);
      // Whole tolerance of three ticks must pass before the report
      cyc(3 * TICK);
      chk_bit(disc, 1'b0);
      for (int n = 0; n < 40 && disc !== 1'b1; n++) @(posedge pclk);
      chk_bit(disc, 1'b1);
      chk_bit(evt, 1'b0);
      apb(1'b1, `SFA_TELEG_OFF, 32'h3);
      cyc(2);
      chk_bit(eval, 1'b0);
      ack(ks[i]);
      chk_bit(disc, 1'b0);
      chk_bit(eval, 1'b1);
      apb(1'b1, `SFA_SACK_OFF, 32'h1);
    end
    // Ramp stop chosen by a locked setting, torque-off at standstill
    apb(1'b1, `SFA_CTRL_OFF, 32'h3);
    fault();
    chk_bit(ramp, 1'b1);
    chk_bit(toff, 1'b0);
    standstill <= 1'b1;
    cyc(2);
    chk_bit(ramp, 1'b0);
    chk_bit(toff, 1'b1);
    standstill <= 1'b0;
    apb(1'b1, `SFA_CTRL_OFF, 32'h0);
    rdchk(`SFA_CTRL_OFF, 32'h3);
    // Power cycle in mid-event clears the event
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    cyc(1);
    chk_bit(evt, 1'b0);
    rdchk(`SFA_CTRL_OFF, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
